/* ahb_to_axi_ddr_write_combining_bridge_tb_top.sv */
// self-checking bench for the two-port ddr bridge
`timescale 1ns/1ps
`default_nettype none
module ahb_to_axi_ddr_write_combining_bridge_tb_top;
  import dbr_pkg::*;
  // ----------------------------------------
  // clock, reset and port signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  logic [1:0] hsel = 2'h0, hwr = 2'h0;
  logic [1:0] htr [2] = '{2'h0, 2'h0};
  logic [2:0] hsz [2] = '{3'h2, 3'h2};
  logic [31:0] ha [2] = '{32'h0, 32'h0};
  logic [31:0] hwd [2] = '{32'h0, 32'h0};
  wire logic [1:0] hro, hresp;
  wire logic [31:0] hrd [2];
  logic [31:0] awaddr, araddr, aw_addr_seen;
  logic [7:0] awlen, arlen, wstrb, aw_len_seen;
  logic [2:0] awsize, arsize;
  logic [1:0] awburst, arburst, bresp, rresp;
  logic [63:0] wdata, rdata;
  logic awvalid, awready, wlast, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rlast, rvalid, rready;
  int failures = 0, n_checks = 0, n_ar = 0, n_b = 0;
  always #5 ref_clk = ~ref_clk;
  dbr_bridge #(.FIFO_DEPTH(FIFO_WORDS)) uut (
    .p0_hsel(hsel[0]), .p0_haddr(ha[0]), .p0_htrans(htr[0]), .p0_hwrite(hwr[0]),
    .p0_hsize(hsz[0]), .p0_hwdata(hwd[0]), .p0_hready(hro[0]), .p0_hreadyout(hro[0]),
    .p0_hrdata(hrd[0]), .p0_hresp(hresp[0]),
    .p1_hsel(hsel[1]), .p1_haddr(ha[1]), .p1_htrans(htr[1]), .p1_hwrite(hwr[1]),
    .p1_hsize(hsz[1]), .p1_hwdata(hwd[1]), .p1_hready(hro[1]), .p1_hreadyout(hro[1]),
    .p1_hrdata(hrd[1]), .p1_hresp(hresp[1]), .*);
  dbr_axi_mem far (.*);
  // axi traffic counters, sampled at the handshake edge
  always @(posedge ref_clk) begin
    if (arvalid && arready) n_ar++;
    if (bvalid && bready) n_b++;
    if (awvalid && awready) begin
      aw_addr_seen <= awaddr;
      aw_len_seen <= awlen;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one ahb transfer: address phase, then data phase until hreadyout
  task automatic ahb(input int p, input logic wr, input logic [31:0] a, input logic [2:0] sz,
                     input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge ref_clk);
    #1;
    hsel[p] = 1'b1;
    htr[p] = 2'h2;
    hwr[p] = wr;
    ha[p] = a;
    hsz[p] = sz;
    @(posedge ref_clk);
    #1;
    hsel[p] = 1'b0;
    htr[p] = 2'h0;
    hwd[p] = d;
    // look just after the edge so the registered answer has settled
    for (i = 0; i < 500; i++) begin
      @(posedge ref_clk);
      #1;
      if (hro[p] === 1'b1) break;
    end
    q = hrd[p];
    if (i == 500) begin
      failures++;
      finish_test();
    end
  endtask
  // bounded wait for a count of write responses
  task automatic wait_b(input int n);
    for (int i = 0; i < 500 && n_b < n; i++) @(posedge ref_clk);
    if (n_b < n) begin
      failures++;
      finish_test();
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // a full line of writes must leave as one four-beat burst
  task automatic t_line();
    logic [31:0] q;
    for (int i = 0; i < 8; i++) ahb(0, 1'b1, 32'h100 + 32'(4*i), 3'h2, 32'hC0DE0000 + 32'(i), q);
    wait_b(1);
    chk(aw_len_seen, AXI_LEN);
    chk(aw_addr_seen, 32'h100);
    for (int i = 0; i < 4; i++) chk(far.mem[32+i], {32'hC0DE0001 + 32'(2*i), 32'hC0DE0000 + 32'(2*i)});
    ahb(1, 1'b0, 32'h104, 3'h2, 32'h0, q);
    chk(q, 32'hC0DE0001);
  endtask
  // pending byte from one port seen by the other; second read is a hit
  task automatic t_partial();
    logic [31:0] q;
    int ar0;
    slow = 1'b1;
    ahb(1, 1'b1, 32'h201, 3'h0, 32'h00007700, q);
    ar0 = n_ar;
    ahb(0, 1'b0, 32'h200, 3'h2, 32'h0, q);
    chk(q, 32'h00007740);
    ahb(0, 1'b0, 32'h204, 3'h2, 32'h0, q);
    chk(q, 32'hFFFFFFBF);
    chk(n_ar - ar0, 64'h1);
  endtask
  // two new lines push both buffers out, the dirty byte reaches memory
  task automatic t_evict();
    logic [31:0] q;
    ahb(0, 1'b0, 32'h300, 3'h2, 32'h0, q);
    chk(q, 32'h00000060);
    ahb(1, 1'b0, 32'h40C, 3'h2, 32'h0, q);
    chk(q, 32'hFFFFFF7E);
    wait_b(2);
    chk(far.mem[64], {32'hFFFFFFBF, 32'h00007740});
    chk({hresp, awsize, awburst}, {2'h0, AXI_SIZE, AXI_INCR});
    chk({arlen, arsize, arburst}, {AXI_LEN, AXI_SIZE, AXI_INCR});
    slow = 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    chk({hro, hresp, awvalid, wvalid, arvalid}, 7'h60);
    #1 rst_n = 1'b1;
    t_line();
    t_partial();
    t_evict();
    finish_test();
  end
endmodule
`default_nettype wire

/* dbr_axi_mem.sv */
// behavioural axi memory slave standing in for the external ddr controller
`timescale 1ns/1ps
`default_nettype none
module dbr_axi_mem (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [63:0] wdata,
  input wire logic [7:0] wstrb,
  input wire logic wlast,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [63:0] rdata,
  output logic [1:0] rresp,
  output logic rlast,
  output logic rvalid,
  input wire logic rready
);
  logic [63:0] mem [256]; // 2 kbyte of beats, preset to a known pattern
  logic [7:0] wa, ra;
  logic [1:0] rn;
  logic w_act, r_act, cyc;
  wire logic st = slow & cyc; // slow mode stalls every other cycle
  initial for (int i = 0; i < 256; i++) mem[i] = {~32'(i), 32'(i)};
  assign awready = !w_act && !bvalid && !st;
  assign wready = w_act && !st;
  assign arready = !r_act && !rvalid && !st;
  assign bresp = 2'h0;
  assign rresp = 2'h0;
  // one write burst and one fill at a time, strobes honoured per byte
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {w_act, r_act, bvalid, rvalid, rlast, cyc, rdata} <= '0;
    end else begin
      cyc <= ~cyc;
      if (awvalid && awready) begin
        wa <= awaddr[10:3];
        w_act <= 1'b1;
      end
      if (wvalid && wready) begin
        for (int b = 0; b < 8; b++) if (wstrb[b]) mem[wa][b*8 +: 8] <= wdata[b*8 +: 8];
        wa <= wa + 8'h01;
        w_act <= !wlast;
        bvalid <= wlast;
      end
      if (bvalid && bready) bvalid <= 1'b0;
      if (arvalid && arready) begin
        ra <= araddr[10:3];
        rn <= 2'h0;
        r_act <= 1'b1;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        rdata <= ~rdata; // released data must not look valid
      end else if (r_act && !rvalid && !st) begin
        rvalid <= 1'b1;
        rdata <= mem[ra];
        rlast <= (rn == 2'h3);
        r_act <= (rn != 2'h3);
        ra <= ra + 8'h01;
        rn <= rn + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* dbr_bridge.sv */
// two ahb-lite slave ports merged onto one 64-bit axi master through two line buffers
`timescale 1ns/1ps
`default_nettype none
// How it works
// - two ahb slave ports, one axi master
// - writes merge in buffers, leave as bursts
// - reads hitting a filled buffer answered locally
// - shared buffers keep both masters coherent
// - exactly two buffers, each read and write
// - axi data path is 64 bits
module dbr_bridge
  import dbr_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_WORDS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic p0_hsel,
  input wire logic [31:0] p0_haddr,
  input wire logic [1:0] p0_htrans,
  input wire logic p0_hwrite,
  input wire logic [2:0] p0_hsize,
  input wire logic [HDW-1:0] p0_hwdata,
  input wire logic p0_hready,
  output logic p0_hreadyout,
  output logic [HDW-1:0] p0_hrdata,
  output logic p0_hresp,
  input wire logic p1_hsel,
  input wire logic [31:0] p1_haddr,
  input wire logic [1:0] p1_htrans,
  input wire logic p1_hwrite,
  input wire logic [2:0] p1_hsize,
  input wire logic [HDW-1:0] p1_hwdata,
  input wire logic p1_hready,
  output logic p1_hreadyout,
  output logic [HDW-1:0] p1_hrdata,
  output logic p1_hresp,
  output logic [31:0] awaddr,
  output logic [7:0] awlen,
  output logic [2:0] awsize,
  output logic [1:0] awburst,
  output logic awvalid,
  input wire logic awready,
  output logic [XDW-1:0] wdata,
  output logic [XSTRB-1:0] wstrb,
  output logic wlast,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [31:0] araddr,
  output logic [7:0] arlen,
  output logic [2:0] arsize,
  output logic [1:0] arburst,
  output logic arvalid,
  input wire logic arready,
  input wire logic [XDW-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rlast,
  input wire logic rvalid,
  output logic rready
);
  // ------------------------------------------------------------
  // port gathering
  // ------------------------------------------------------------
  logic h_sel [NPORT];
  logic h_go [NPORT];          // address phase qualifier
  logic h_wr [NPORT];
  logic [31:0] h_addr [NPORT];
  logic [2:0] h_size [NPORT];
  logic [HDW-1:0] h_wd [NPORT];
  assign h_sel[0] = p0_hsel;
  assign h_sel[1] = p1_hsel;
  assign h_go[0] = p0_htrans[1] && p0_hready;
  assign h_go[1] = p1_htrans[1] && p1_hready;
  assign h_wr[0] = p0_hwrite;
  assign h_wr[1] = p1_hwrite;
  assign h_addr[0] = p0_haddr;
  assign h_addr[1] = p1_haddr;
  assign h_size[0] = p0_hsize;
  assign h_size[1] = p1_hsize;
  assign h_wd[0] = p0_hwdata;
  assign h_wd[1] = p1_hwdata;
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  dbr_state_t st_reg, st_next;
  logic pq_v_reg [NPORT], pq_v_next [NPORT];     // request pending per port
  logic pq_w_reg [NPORT], pq_w_next [NPORT];     // pending request is a write
  logic pq_wv_reg [NPORT], pq_wv_next [NPORT];   // write data captured
  logic [31:0] pq_a_reg [NPORT], pq_a_next [NPORT];
  logic [2:0] pq_s_reg [NPORT], pq_s_next [NPORT];
  logic [HDW-1:0] pq_d_reg [NPORT], pq_d_next [NPORT];
  logic hrdy_reg [NPORT], hrdy_next [NPORT];      // hreadyout per port
  logic [HDW-1:0] hrd_reg [NPORT], hrd_next [NPORT];
  logic cur_reg, cur_next;        // port being served
  logic rr_reg, rr_next;          // port preferred at next pick
  logic busy_reg, busy_next;      // current request not yet answered
  // the two line buffers: tag, valid, filled from memory, dirty bytes, data
  logic bv_reg [NBUF], bv_next [NBUF];
  logic bf_reg [NBUF], bf_next [NBUF];
  logic [TAG_BITS-1:0] bt_reg [NBUF], bt_next [NBUF];
  logic [31:0] bm_reg [NBUF], bm_next [NBUF];
  logic [XDW-1:0] bd_reg [NBUF][BEATS], bd_next [NBUF][BEATS];
  logic vict_reg, vict_next;      // round-robin victim when both in use
  logic fl_reg, fl_next;          // buffer being flushed or filled
  logic [1:0] beat_reg, beat_next;
  logic awv_reg, awv_next, arv_reg, arv_next;
  // ------------------------------------------------------------
  // lookup of the current request
  // ------------------------------------------------------------
  logic [TAG_BITS-1:0] cur_tag;
  logic hit0, hit1, hit, hit_idx, vic;
  logic [7:0] lanes;
  logic [1:0] cur_beat;
  logic elig0, elig1;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [FIFO_W-1:0] fifo_in_data, fifo_out_data;
  assign cur_tag = pq_a_reg[cur_reg][31:OFF_BITS];
  assign cur_beat = pq_a_reg[cur_reg][4:3];
  assign hit0 = bv_reg[0] && (bt_reg[0] == cur_tag);
  assign hit1 = bv_reg[1] && (bt_reg[1] == cur_tag);
  assign hit = hit0 || hit1;
  assign hit_idx = hit1;
  // an unused buffer is taken before anything is evicted
  assign vic = !bv_reg[0] ? 1'b0 : (!bv_reg[1] ? 1'b1 : vict_reg);
  assign lanes = dbr_lanes(pq_a_reg[cur_reg][2:0], pq_s_reg[cur_reg]);
  assign elig0 = pq_v_reg[0] && (!pq_w_reg[0] || pq_wv_reg[0]);
  assign elig1 = pq_v_reg[1] && (!pq_w_reg[1] || pq_wv_reg[1]);
  assign fifo_in_data = {bm_reg[fl_reg][{beat_reg, 3'h0} +: 8], bd_reg[fl_reg][beat_reg]};

  // next-state of the whole sequencer
  always_comb begin
    st_next = st_reg;
    pq_v_next = pq_v_reg;
    pq_w_next = pq_w_reg;
    pq_wv_next = pq_wv_reg;
    pq_a_next = pq_a_reg;
    pq_s_next = pq_s_reg;
    pq_d_next = pq_d_reg;
    hrdy_next = hrdy_reg;
    hrd_next = hrd_reg;
    cur_next = cur_reg;
    rr_next = rr_reg;
    busy_next = busy_reg;
    bv_next = bv_reg;
    bf_next = bf_reg;
    bt_next = bt_reg;
    bm_next = bm_reg;
    bd_next = bd_reg;
    vict_next = vict_reg;
    fl_next = fl_reg;
    beat_next = beat_reg;
    awv_next = awv_reg;
    arv_next = arv_reg;
    // each port takes its own address phase and stalls with wait states
    for (int p = 0; p < NPORT; p++) begin
      if (h_sel[p] && h_go[p] && hrdy_reg[p]) begin
        pq_v_next[p] = 1'b1;
        pq_w_next[p] = h_wr[p];
        pq_a_next[p] = h_addr[p];
        pq_s_next[p] = h_size[p];
        pq_wv_next[p] = 1'b0;
        hrdy_next[p] = 1'b0;
      end else if (pq_v_reg[p] && pq_w_reg[p] && !pq_wv_reg[p]) begin
        // first data-phase cycle: write data is valid now
        pq_d_next[p] = h_wd[p];
        pq_wv_next[p] = 1'b1;
      end
    end
    case (st_reg)
      ST_IDLE: begin
        // round robin keeps one busy master from starving the other
        if (elig0 || elig1) begin
          cur_next = (rr_reg ? elig1 : !elig0);
          rr_next = !(rr_reg ? elig1 : !elig0);
          busy_next = 1'b1;
          st_next = ST_LOOK;
        end
      end
      ST_LOOK: begin
        if (hit && (pq_w_reg[cur_reg] || bf_reg[hit_idx])) begin
          if (pq_w_reg[cur_reg]) begin
            // merge the write into the line and mark its bytes dirty
            for (int b = 0; b < XSTRB; b++) begin
              if (lanes[b]) begin
                bd_next[hit_idx][cur_beat][8*b +: 8] = pq_d_reg[cur_reg][8*(b%4) +: 8];
                bm_next[hit_idx][{cur_beat, 3'(b)}] = 1'b1;
              end
            end
          end else begin
            hrd_next[cur_reg] = pq_a_reg[cur_reg][2] ?
                bd_reg[hit_idx][cur_beat][63:32] : bd_reg[hit_idx][cur_beat][31:0];
          end
          hrdy_next[cur_reg] = 1'b1;
          pq_v_next[cur_reg] = 1'b0;
          pq_wv_next[cur_reg] = 1'b0;
          busy_next = 1'b0;
          // a fully written line leaves at once as one burst
          if (pq_w_reg[cur_reg] && ((bm_reg[hit_idx] | {24'h000000, lanes} << {cur_beat, 3'h0})
              == MASK_FULL)) begin
            fl_next = hit_idx;
            awv_next = 1'b1;
            st_next = ST_AW;
          end else begin
            st_next = ST_IDLE;
          end
        end else if (hit) begin
          // read of a line that holds only written bytes: fetch the rest
          fl_next = hit_idx;
          arv_next = 1'b1;
          st_next = ST_AR;
        end else if (bm_reg[vic] != MASK_NONE) begin
          fl_next = vic;                      // dirty victim goes out first
          awv_next = 1'b1;
          st_next = ST_AW;
        end else begin
          // claim a clean buffer; the lookup repeats next cycle and hits
          bv_next[vic] = 1'b1;
          bf_next[vic] = 1'b0;
          bt_next[vic] = cur_tag;
          vict_next = !vic;
        end
      end
      ST_AW: begin
        if (awready) begin
          awv_next = 1'b0;
          beat_next = 2'h0;
          st_next = ST_W;
        end
      end
      ST_W: begin
        if (fifo_in_ready) begin
          beat_next = beat_reg + 2'h1;
          if (beat_reg == LAST_BEAT) begin
            st_next = ST_B;
          end
        end
      end
      ST_B: begin
        // the line is clean only once memory has taken it, so a later
        // fill can never overtake the write
        if (bvalid) begin
          bm_next[fl_reg] = MASK_NONE;
          st_next = busy_reg ? ST_LOOK : ST_IDLE;
        end
      end
      ST_AR: begin
        if (arready) begin
          arv_next = 1'b0;
          beat_next = 2'h0;
          st_next = ST_R;
        end
      end
      ST_R: begin
        if (rvalid) begin
          // memory bytes fill in only where no newer write is held
          for (int b = 0; b < XSTRB; b++) begin
            if (!bm_reg[fl_reg][{beat_reg, 3'(b)}]) begin
              bd_next[fl_reg][beat_reg][8*b +: 8] = rdata[8*b +: 8];
            end
          end
          beat_next = beat_reg + 2'h1;
          if (rlast) begin
            bf_next[fl_reg] = 1'b1;
            st_next = ST_LOOK;
          end
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_IDLE;
      for (int p = 0; p < NPORT; p++) begin
        pq_v_reg[p] <= 1'b0;
        pq_w_reg[p] <= 1'b0;
        pq_wv_reg[p] <= 1'b0;
        pq_a_reg[p] <= 32'h00000000;
        pq_s_reg[p] <= 3'h0;
        pq_d_reg[p] <= 32'h00000000;
        hrdy_reg[p] <= 1'b1;
        hrd_reg[p] <= 32'h00000000;
      end
      for (int i = 0; i < NBUF; i++) begin
        bv_reg[i] <= 1'b0;
        bf_reg[i] <= 1'b0;
        bt_reg[i] <= '0;
        bm_reg[i] <= MASK_NONE;
        for (int k = 0; k < BEATS; k++) begin
          bd_reg[i][k] <= 64'h0000000000000000;
        end
      end
      cur_reg <= 1'b0;
      rr_reg <= 1'b0;
      busy_reg <= 1'b0;
      vict_reg <= 1'b0;
      fl_reg <= 1'b0;
      beat_reg <= 2'h0;
      awv_reg <= 1'b0;
      arv_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      pq_v_reg <= pq_v_next;
      pq_w_reg <= pq_w_next;
      pq_wv_reg <= pq_wv_next;
      pq_a_reg <= pq_a_next;
      pq_s_reg <= pq_s_next;
      pq_d_reg <= pq_d_next;
      hrdy_reg <= hrdy_next;
      hrd_reg <= hrd_next;
      bv_reg <= bv_next;
      bf_reg <= bf_next;
      bt_reg <= bt_next;
      bm_reg <= bm_next;
      bd_reg <= bd_next;
      cur_reg <= cur_next;
      rr_reg <= rr_next;
      busy_reg <= busy_next;
      vict_reg <= vict_next;
      fl_reg <= fl_next;
      beat_reg <= beat_next;
      awv_reg <= awv_next;
      arv_reg <= arv_next;
    end
  end
  // ------------------------------------------------------------
  // write beat fifo and registered w channel
  // ------------------------------------------------------------
  dbr_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(st_reg == ST_W),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );
  logic wv_reg, wv_next, wl_reg, wl_next;
  logic [XDW-1:0] wd_reg, wd_next;
  logic [XSTRB-1:0] ws_reg, ws_next;
  logic [1:0] wb_reg, wb_next;   // beats sent in this burst
  // stall on wready reaches back into the fifo and then the sequencer
  assign fifo_pop = fifo_out_valid && (!wv_reg || wready);

  // output stage keeps w signals straight from flops
  always_comb begin
    wv_next = wv_reg;
    wl_next = wl_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    wb_next = wb_reg;
    if (fifo_pop) begin
      wv_next = 1'b1;
      wd_next = fifo_out_data[XDW-1:0];
      ws_next = fifo_out_data[FIFO_W-1:XDW];
      wl_next = (wb_reg == LAST_BEAT);
      wb_next = wb_reg + 2'h1;
    end else if (wready) begin
      wv_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wv_reg <= 1'b0;
      wl_reg <= 1'b0;
      wd_reg <= 64'h0000000000000000;
      ws_reg <= 8'h00;
      wb_reg <= 2'h0;
    end else begin
      wv_reg <= wv_next;
      wl_reg <= wl_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      wb_reg <= wb_next;
    end
  end
  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic on_reg;   // ready flops for b and r, high from first edge after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_reg <= 1'b0;
    end else begin
      on_reg <= 1'b1;
    end
  end
  assign p0_hreadyout = hrdy_reg[0];
  assign p1_hreadyout = hrdy_reg[1];
  assign p0_hrdata = hrd_reg[0];
  assign p1_hrdata = hrd_reg[1];
  assign p0_hresp = HRESP_OKAY;
  assign p1_hresp = HRESP_OKAY;
  assign awaddr = {bt_reg[fl_reg], LINE_OFF0};
  assign araddr = {bt_reg[fl_reg], LINE_OFF0};
  assign awlen = AXI_LEN;
  assign arlen = AXI_LEN;
  assign awsize = AXI_SIZE;
  assign arsize = AXI_SIZE;
  assign awburst = AXI_INCR;
  assign arburst = AXI_INCR;
  assign awvalid = awv_reg;
  assign arvalid = arv_reg;
  assign wvalid = wv_reg;
  assign wdata = wd_reg;
  assign wstrb = ws_reg;
  assign wlast = wl_reg;
  assign bready = on_reg;
  assign rready = on_reg;
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] wcnt_reg;   // beats handed over since the last wlast
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wcnt_reg <= 3'h0;
    end else if (wvalid && wready) begin
      wcnt_reg <= wlast ? 3'h0 : wcnt_reg + 3'h1;
    end
  end
  sequence s_fill_end;
    st_reg == ST_R && rvalid && rlast;
  endsequence
  sequence s_read_hit;
    st_reg == ST_LOOK && hit && !pq_w_reg[cur_reg] && bf_reg[hit_idx];
  endsequence
  chk_addr_wait: assert property (p0_hsel && p0_htrans[1] && p0_hready && p0_hreadyout |=> !p0_hreadyout) else $error("port 0 took a transfer without a wait state");
  chk_burst_beats: assert property (wvalid && wready && wlast |-> wcnt_reg == 3'h3) else $error("write burst is not four beats");
  chk_hit_local: assert property (s_read_hit |=> !arvalid && st_reg == ST_IDLE) else $error("buffered read went to memory");
  chk_tags_unique: assert property (bv_reg[0] && bv_reg[1] |-> bt_reg[0] != bt_reg[1]) else $error("one line held in both buffers");
  chk_fill_alone: assert property (arvalid |-> !awvalid && !wvalid && st_reg == ST_AR) else $error("fill overlaps a write burst");
  chk_wdata_hold: assert property (wvalid && !wready |=> wvalid && $stable(wdata) && $stable(wstrb)) else $error("w beat changed under stall");
  // both masks are watched: fl_reg itself moves on this edge, so indexing by it would compare two buffers
  chk_partial_fill: assert property (st_reg == ST_LOOK && hit && !pq_w_reg[cur_reg] && !bf_reg[hit_idx] |=> arvalid && $stable(bm_reg[0]) && $stable(bm_reg[1])) else $error("read of partial line did not fetch");
  chk_fill_resume: assert property (s_fill_end |=> st_reg == ST_LOOK ##1 (st_reg == ST_IDLE && hrdy_reg[cur_reg])) else $error("fill did not end in an answer");
endmodule
`default_nettype wire

/* dbr_fifo.sv */
// first-in first-out store for write burst beats
`timescale 1ns/1ps
`default_nettype none
module dbr_fifo #(
  parameter int W = 72,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  // ------------------------------------------------------------
  // storage and pointers
  // ------------------------------------------------------------
  logic [W-1:0] mem [DEPTH];   // beat storage, no reset needed
  logic [PW:0] wr_reg, wr_next; // extra bit tells full from empty
  logic [PW:0] rd_reg, rd_next;
  logic push, pop;

  assign in_ready = !((wr_reg[PW] != rd_reg[PW]) && (wr_reg[PW-1:0] == rd_reg[PW-1:0]));
  assign out_valid = (wr_reg != rd_reg);
  assign out_data = mem[rd_reg[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer advance
  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (push) begin
      wr_next = wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = rd_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // memory write kept apart so the array needs no reset
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_reg[PW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

/* dbr_pkg.sv */
// constants, state codes and decode helpers for the two-port ddr bridge
`default_nettype none
package dbr_pkg;
  // ------------------------------------------------------------
  // bus widths and buffer geometry
  // ------------------------------------------------------------
  localparam int NPORT = 2;          // upstream ahb-lite ports
  localparam int NBUF = 2;           // combining buffers
  localparam int HDW = 32;           // ahb data width
  localparam int XDW = 64;           // axi data width
  localparam int XSTRB = 8;          // axi byte lanes
  localparam int BEATS = 4;          // axi beats per buffer line
  localparam int LINE_BYTES = 32;    // bytes per buffer line
  localparam int OFF_BITS = 5;       // address bits inside a line
  localparam int TAG_BITS = 27;      // address bits above a line
  localparam int FIFO_WORDS = 16;    // write data fifo depth
  localparam int FIFO_W = 72;        // strobe plus data
  // ------------------------------------------------------------
  // fixed axi and ahb encodings
  // ------------------------------------------------------------
  localparam logic [7:0] AXI_LEN = 8'h03;        // four beats
  localparam logic [2:0] AXI_SIZE = 3'h3;        // eight bytes per beat
  localparam logic [1:0] AXI_INCR = 2'h1;        // incrementing burst
  localparam logic [OFF_BITS-1:0] LINE_OFF0 = 5'h00;
  localparam logic [31:0] MASK_FULL = 32'hFFFFFFFF;
  localparam logic [31:0] MASK_NONE = 32'h00000000;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic HRESP_OKAY = 1'h0;
  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,   // waiting for a port to be ready
    ST_LOOK = 7'h02,   // buffer lookup for the current request
    ST_AW = 7'h04,     // write burst address
    ST_W = 7'h08,      // line beats into the write fifo
    ST_B = 7'h10,      // waiting for the write response
    ST_AR = 7'h20,     // fill burst address
    ST_R = 7'h40       // fill beats coming back
  } dbr_state_t;
  // byte lanes of a 64-bit beat touched by an ahb transfer
  function automatic logic [7:0] dbr_lanes(input logic [2:0] addr, input logic [2:0] size);
    logic [7:0] m;
    m = 8'h0F;
    case (size)
      3'h0: m = 8'h01;
      3'h1: m = 8'h03;
      default: m = 8'h0F;
    endcase
    return 8'(m << addr);
  endfunction
endpackage
`default_nettype wire
